// ---- rtl/lighting_engine_exec_control.sv ----
// enable, execution and mode control of two lighting sequence engines behind a serial slave
`timescale 1ns/1ns
`include "lighting_engine_params.svh"
module lighting_engine_exec_control (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // engine core
  input wire logic [1:0] instr_done,
  input wire logic engine_busy,
  output lighting_engine_pkg::engine_cmd_t [1:0] seq_cmd,
  output lighting_engine_pkg::prog_wr_t prog_wr,
  // device state
  output logic normal_mode
);
  lighting_engine_pkg::bus_state_t bus_reg;
  logic scl_reg, sda_reg, ack_reg, rw_reg, wr_pulse;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg, reg_addr_reg, rdata;
  logic [1:0] byte_reg;
  logic chip_en_reg;
  logic [1:0] run_reg [2];
  logic [1:0] op_reg [2];
  logic [6:0] pc_reg [2];
  logic [1:0] busy_run_reg, adv_reg, go_reg, abort_reg;
  logic [15:0] start_reg;
  logic any_load;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  logic [7:0] wr_addr, wr_data;

  assign sda_out = 1'b0;
  assign scl_rise = scl_in & ~scl_reg;
  assign scl_fall = ~scl_in & scl_reg;
  assign start_cond = scl_in & scl_reg & sda_reg & ~sda_in;
  assign stop_cond = scl_in & scl_reg & ~sda_reg & sda_in;
  assign wr_addr = reg_addr_reg;
  assign wr_data = shift_reg;
  assign any_load = (op_reg[0] == lighting_engine_pkg::OP_LOAD) | (op_reg[1] == lighting_engine_pkg::OP_LOAD);

  function automatic logic [6:0] pc_inc(input logic [6:0] pc);
    pc_inc = (pc == `PC_LAST) ? `PC_RESET : pc + 7'h01;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
    end else begin
      scl_reg <= scl_in;
      sda_reg <= sda_in;
    end
  end

  // serial slave: address, register byte, data bytes with auto increment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_reg <= lighting_engine_pkg::BUS_IDLE;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_reg <= 2'h0;
      reg_addr_reg <= 8'h00;
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      sda_oe <= 1'b0;
      wr_pulse <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (stop_cond) begin
        bus_reg <= lighting_engine_pkg::BUS_IDLE;
        sda_oe <= 1'b0;
      end else if (start_cond) begin
        bus_reg <= lighting_engine_pkg::BUS_RECV;
        bit_reg <= 4'h0;
        byte_reg <= 2'h0;
        ack_reg <= 1'b0;
        sda_oe <= 1'b0;
      end else begin
        case (bus_reg)
          lighting_engine_pkg::BUS_RECV: begin
            if (scl_rise && bit_reg < 4'h8) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8 && !ack_reg) begin
              ack_reg <= 1'b1;
              sda_oe <= 1'b1;
              if (byte_reg == 2'h0) begin
                rw_reg <= shift_reg[0];
                if (shift_reg[7:1] != `DEV_ADDR) begin
                  bus_reg <= lighting_engine_pkg::BUS_IDLE;
                  sda_oe <= 1'b0;
                end
              end else if (byte_reg == 2'h1) begin
                reg_addr_reg <= shift_reg;
              end else begin
                wr_pulse <= 1'b1;
              end
              if (byte_reg != 2'h3) begin
                byte_reg <= byte_reg + 2'h1;
              end
            end else if (scl_fall && ack_reg) begin
              ack_reg <= 1'b0;
              if (rw_reg) begin
                bus_reg <= lighting_engine_pkg::BUS_SEND;
                sda_oe <= ~rdata[7];
                shift_reg <= {rdata[6:0], 1'b0};
                bit_reg <= 4'h1;
              end else begin
                sda_oe <= 1'b0;
                bit_reg <= 4'h0;
              end
            end
            if (wr_pulse) begin
              reg_addr_reg <= reg_addr_reg + 8'h01;
            end
          end
          lighting_engine_pkg::BUS_SEND: begin
            if (scl_fall && bit_reg < 4'h8) begin
              sda_oe <= ~shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_reg <= bit_reg + 4'h1;
            end else if (scl_fall && bit_reg == 4'h8) begin
              sda_oe <= 1'b0;
              bit_reg <= 4'h9;
            end else if (scl_rise && bit_reg == 4'h9) begin
              bit_reg <= 4'h0;
              shift_reg <= rdata;
              if (sda_in) begin
                bus_reg <= lighting_engine_pkg::BUS_IDLE;
              end
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // read data; no auto increment on reads
  always_comb begin
    rdata = 8'h00;
    case (reg_addr_reg)
      `ADDR_CTRL1: rdata = {1'b0, chip_en_reg, run_reg[0], run_reg[1], 2'b00};
      `ADDR_CTRL2: rdata = {2'b00, op_reg[0], op_reg[1], 2'b00};
      `ADDR_PC_A: rdata = (run_reg[0] == lighting_engine_pkg::RUN_HOLD) ? {1'b0, pc_reg[0]} : 8'h00;
      `ADDR_PC_B: rdata = (run_reg[1] == lighting_engine_pkg::RUN_HOLD) ? {1'b0, pc_reg[1]} : 8'h00;
      `ADDR_STATUS: rdata = {7'h00, engine_busy};
      default: rdata = 8'h00;
    endcase
  end

  // enable bit and power-up sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chip_en_reg <= 1'b0;
      start_reg <= 16'h0000;
      normal_mode <= 1'b0;
    end else begin
      if (wr_pulse && wr_addr == `ADDR_CTRL1) begin
        chip_en_reg <= wr_data[`CHIP_EN_BIT];
      end
      if (!chip_en_reg) begin
        start_reg <= 16'h0000;
        normal_mode <= 1'b0;
      end else if (start_reg == 16'(`STARTUP_CYC - 1)) begin
        normal_mode <= 1'b1;
      end else begin
        start_reg <= start_reg + 16'h0001;
      end
    end
  end

  // per-engine fields, counters and instruction issue
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int e = 0; e < 2; e++) begin
        run_reg[e] <= 2'(`CTRL_RESET);
        op_reg[e] <= 2'(`CTRL_RESET);
        pc_reg[e] <= `PC_RESET;
      end
      busy_run_reg <= 2'b00;
      adv_reg <= 2'b00;
      go_reg <= 2'b00;
      abort_reg <= 2'b00;
    end else begin
      for (int e = 0; e < 2; e++) begin
        automatic int lsb = (e == 0) ? `FIELD_A_LSB : `FIELD_B_LSB;
        automatic logic [7:0] pc_addr = (e == 0) ? `ADDR_PC_A : `ADDR_PC_B;
        automatic logic done = instr_done[e] & busy_run_reg[e];
        automatic logic [1:0] new_op = wr_data[lsb+:2];
        automatic logic op_wr = wr_pulse && wr_addr == `ADDR_CTRL2;
        automatic logic load_ok = op_wr && new_op == lighting_engine_pkg::OP_LOAD
          && op_reg[e] == lighting_engine_pkg::OP_DISABLED;
        automatic logic stop_now = busy_run_reg[e] && (op_reg[e] != lighting_engine_pkg::OP_RUN || !normal_mode);
        go_reg[e] <= 1'b0;
        abort_reg[e] <= 1'b0;
        if (wr_pulse && wr_addr == `ADDR_CTRL1) begin
          run_reg[e] <= wr_data[lsb+:2];
        end else if (done && run_reg[e] inside {lighting_engine_pkg::RUN_STEP, lighting_engine_pkg::RUN_ONCE}) begin
          run_reg[e] <= lighting_engine_pkg::RUN_HOLD;
        end
        if (op_wr && (new_op != lighting_engine_pkg::OP_LOAD || load_ok)) begin
          op_reg[e] <= new_op;
        end
        if (load_ok) begin
          pc_reg[e] <= `PC_RESET;
        end else if (wr_pulse && wr_addr == pc_addr && run_reg[e] == lighting_engine_pkg::RUN_HOLD) begin
          pc_reg[e] <= wr_data[6:0];
        end else if (done && adv_reg[e]) begin
          pc_reg[e] <= pc_inc(pc_reg[e]);
        end
        if (stop_now) begin
          busy_run_reg[e] <= 1'b0;
          abort_reg[e] <= 1'b1;
        end else if (done) begin
          busy_run_reg[e] <= 1'b0;
        end else if (!busy_run_reg[e] && normal_mode && !any_load && op_reg[e] == lighting_engine_pkg::OP_RUN
          && run_reg[e] != lighting_engine_pkg::RUN_HOLD) begin
          busy_run_reg[e] <= 1'b1;
          go_reg[e] <= 1'b1;
          adv_reg[e] <= run_reg[e] != lighting_engine_pkg::RUN_ONCE;
        end
      end
    end
  end

  always_comb begin
    for (int e = 0; e < 2; e++) begin
      seq_cmd[e].go = go_reg[e];
      seq_cmd[e].abort = abort_reg[e];
      seq_cmd[e].pc = pc_reg[e];
    end
  end

  // program memory writes gated by load mode and busy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_wr <= '0;
    end else begin
      prog_wr.valid <= wr_pulse && wr_addr >= `ADDR_PROG_BASE && any_load && !engine_busy;
      prog_wr.addr <= wr_addr - `ADDR_PROG_BASE;
      prog_wr.data <= wr_data;
    end
  end

  function automatic logic stop_now_a();
    stop_now_a = op_reg[0] != 2'b10 || !normal_mode;
  endfunction

  standby_a: assert property (@(posedge clk) disable iff (!rst_n) !chip_en_reg |=> !normal_mode)
    else $error("normal mode while disabled");
  pc_refused_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && wr_addr == `ADDR_PC_A && run_reg[0] != 2'b00 && !instr_done[0] |=> $stable(pc_reg[0]))
    else $error("counter written outside hold");
  step_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy_run_reg[0] && instr_done[0] && !stop_now_a() && run_reg[0] == 2'b01 && !wr_pulse
    |=> run_reg[0] == 2'b00 && pc_reg[0] == pc_inc($past(pc_reg[0])))
    else $error("step did not clear or advance");
  once_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy_run_reg[0] && instr_done[0] && !stop_now_a() && adv_reg[0] == 1'b0 && !wr_pulse |=> $stable(pc_reg[0]))
    else $error("execute once moved counter");
  load_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && wr_addr == `ADDR_CTRL2 && wr_data[5:4] == 2'b01 && op_reg[0] == 2'b00
    |=> op_reg[0] == 2'b01 && pc_reg[0] == 7'h00)
    else $error("load entry did not clear counter");
  no_run_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_pulse && wr_addr == `ADDR_CTRL2 && wr_data[5:4] == 2'b01 && op_reg[0] == 2'b10 |=> op_reg[0] == 2'b10)
    else $error("run to load accepted");
  load_hold_a: assert property (@(posedge clk) disable iff (!rst_n) any_load |=> go_reg == 2'b00)
    else $error("engine issued during load");
  halt_abort_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy_run_reg[1] && op_reg[1] == 2'b11 |=> abort_reg[1] && !busy_run_reg[1])
    else $error("halt did not abort");
  prog_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    prog_wr.valid |-> $past(any_load) && !$past(engine_busy))
    else $error("program write not gated");
  startup_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(chip_en_reg) |-> !normal_mode [*2])
    else $error("normal mode without power-up delay");
  startup_len_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(normal_mode) |-> $past(chip_en_reg, `STARTUP_CYC))
    else $error("power-up sequence too short");

  free_run_c: cover property (@(posedge clk) disable iff (!rst_n) go_reg[0] && run_reg[0] == 2'b10);
  step_c: cover property (@(posedge clk) disable iff (!rst_n) go_reg[1] && run_reg[1] == 2'b01);
  prog_wr_c: cover property (@(posedge clk) disable iff (!rst_n) prog_wr.valid);
endmodule

// ---- rtl/lighting_engine_params.svh ----
// offsets, field positions, reset values and timing counts of the control block
`ifndef LIGHTING_ENGINE_PARAMS_SVH
`define LIGHTING_ENGINE_PARAMS_SVH
`define DEV_ADDR 7'h33
`define ADDR_CTRL1 8'h00
`define ADDR_CTRL2 8'h01
`define ADDR_PC_A 8'h37
`define ADDR_PC_B 8'h38
`define ADDR_STATUS 8'h3a
`define ADDR_PROG_BASE 8'h50
`define CHIP_EN_BIT 6
`define FIELD_A_LSB 4
`define FIELD_B_LSB 2
`define CTRL_RESET 8'h00
`define PC_RESET 7'h00
`define PC_LAST 7'h7f
`define CLK_PERIOD_NS 40
`define STARTUP_TIME_NS 2000
`define STARTUP_CYC ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- rtl/lighting_engine_pkg.sv ----
// types shared by the lighting engine control block
package lighting_engine_pkg;
  typedef enum logic [1:0] {
    RUN_HOLD = 2'b00,
    RUN_STEP = 2'b01,
    RUN_FREE = 2'b10,
    RUN_ONCE = 2'b11
  } run_field_t;
  typedef enum logic [1:0] {
    OP_DISABLED = 2'b00,
    OP_LOAD = 2'b01,
    OP_RUN = 2'b10,
    OP_HALT = 2'b11
  } op_state_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RECV = 2'b01,
    BUS_SEND = 2'b10
  } bus_state_t;
  typedef struct packed {
    logic go;
    logic abort;
    logic [6:0] pc;
  } engine_cmd_t;
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } prog_wr_t;
endpackage

// ---- sim/i2c_host_model.sv ----
// serial bus host model that reaches the control block registers
`timescale 1ns/1ns
`include "lighting_engine_params.svh"
module i2c_host_model (
  // clock
  input wire logic clk,
  // bus lines
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic sda_drv = 1'b1;
  // pull-up wire, pulled low by either party
  assign sda = sda_drv & ~sda_oe;
  initial scl = 1'b1;
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    scl = 1'b0;
    tick(1);
  endtask
  task automatic start();
    sda_drv = 1'b1;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b0;
    tick(1);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    tick(1);
    scl = 1'b1;
    tick(2);
    sda_drv = 1'b1;
    tick(2);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(1'b1, r);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d0, input logic [7:0] d1, input logic two,
                    output logic ack);
    logic a0, a1, a2, a3;
    a3 = 1'b1;
    start();
    send({`DEV_ADDR, 1'b0}, a0);
    send(ra, a1);
    send(d0, a2);
    if (two) send(d1, a3);
    stop();
    ack = a0 & a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] d, output logic ack);
    logic a0, a1, a2;
    start();
    send({`DEV_ADDR, 1'b0}, a0);
    send(ra, a1);
    start();
    send({`DEV_ADDR, 1'b1}, a2);
    recv(d);
    stop();
    ack = a0 & a1 & a2;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench of the lighting engine control block
`timescale 1ns/1ns
module tb_top;
  logic clk, rst_n, scl, sda, sda_out, sda_oe, normal_mode, ack;
  logic busy_force = 1'b0;
  logic engine_busy = 1'b0;
  logic [1:0] instr_done = 2'b00;
  logic [7:0] rd_v, pw_addr, pw_data;
  logic [6:0] go_pc [2];
  lighting_engine_pkg::engine_cmd_t [1:0] seq_cmd;
  lighting_engine_pkg::prog_wr_t prog_wr;
  int n_errors = 0, n_tests = 0, dur = 4, n_pw = 0;
  int cnt [2] = '{0, 0}, n_go [2] = '{0, 0}, n_ab [2] = '{0, 0};
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  lighting_engine_exec_control u_dut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .instr_done(instr_done), .engine_busy(engine_busy), .seq_cmd(seq_cmd), .prog_wr(prog_wr),
    .normal_mode(normal_mode));
  i2c_host_model u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  // engine core stand-in: busy for dur cycles after each go
  always @(negedge clk) begin
    engine_busy <= busy_force | (cnt[0] != 0) | (cnt[1] != 0) | seq_cmd[0].go | seq_cmd[1].go;
    for (int e = 0; e < 2; e++) begin
      instr_done[e] <= (cnt[e] == 1) & ~seq_cmd[e].abort;
      if (seq_cmd[e].abort) cnt[e] = 0;
      else if (seq_cmd[e].go) cnt[e] = dur;
      else if (cnt[e] != 0) cnt[e]--;
    end
  end
  always @(posedge clk) begin
    for (int e = 0; e < 2; e++) begin
      if (seq_cmd[e].go === 1'b1) begin
        n_go[e]++;
        go_pc[e] <= seq_cmd[e].pc;
      end
      if (seq_cmd[e].abort === 1'b1) n_ab[e]++;
    end
    if (prog_wr.valid === 1'b1) begin
      n_pw++;
      pw_addr <= prog_wr.addr;
      pw_data <= prog_wr.data;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    u_host.wr(ra, d, 8'h00, 1'b0, ack);
    chk("write ack", 8'h01, {7'h00, ack});
  endtask
  task automatic rchk(input logic [7:0] ra, input logic [7:0] exp);
    u_host.rd(ra, rd_v, ack);
    chk("read ack", 8'h01, {7'h00, ack});
    chk($sformatf("reg %h", ra), exp, rd_v);
  endtask
  task automatic t_power;
    rchk(8'h00, 8'h00);
    rchk(8'h01, 8'h00);
    u_host.wr(8'h00, 8'h00, 8'h2c, 1'b1, ack);
    chk("pair write ack", 8'h01, {7'h00, ack});
    chk("sda drive", 8'h00, {7'h00, sda_out});
    rchk(8'h01, 8'h2c);
    chk("standby", 8'h00, {7'h00, normal_mode});
    wr(8'h00, 8'h40);
    cyc(30);
    chk("startup early", 8'h00, {7'h00, normal_mode});
    cyc(30);
    chk("startup done", 8'h01, {7'h00, normal_mode});
    wr(8'h01, 8'h00);
  endtask
  task automatic t_load;
    int g, p;
    wr(8'h37, 8'h05);
    rchk(8'h37, 8'h05);
    chk("pc a", 8'h05, {1'b0, seq_cmd[0].pc});
    wr(8'h01, 8'h10);
    chk("pc a load", 8'h00, {1'b0, seq_cmd[0].pc});
    rchk(8'h3a, 8'h00);
    p = n_pw;
    wr(8'h52, 8'ha5);
    chk("prog count", 8'(p + 1), 8'(n_pw));
    chk("prog addr", 8'h02, pw_addr);
    chk("prog data", 8'ha5, pw_data);
    busy_force = 1'b1;
    rchk(8'h3a, 8'h01);
    wr(8'h53, 8'h3c);
    busy_force = 1'b0;
    chk("prog busy", 8'(p + 1), 8'(n_pw));
    wr(8'h01, 8'h18);
    wr(8'h00, 8'h48);
    g = n_go[1];
    cyc(20);
    chk("go b in load", 8'(g), 8'(n_go[1]));
    wr(8'h01, 8'h08);
    cyc(10);
    chk("go b resumes", 8'h01, {7'h00, n_go[1] > g});
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h04);
    rchk(8'h01, 8'h08);
    wr(8'h50, 8'h11);
    chk("prog no load", 8'(p + 1), 8'(n_pw));
    wr(8'h01, 8'h00);
  endtask
  task automatic t_step;
    int g;
    logic [7:0] pa, sh;
    for (int e = 0; e < 2; e++) begin
      pa = 8'h37 + 8'(e);
      sh = (e == 0) ? 8'h10 : 8'h04;
      wr(pa, 8'h7f);
      wr(8'h01, 8'(sh * 2));
      g = n_go[e];
      wr(8'h00, 8'h40 | sh);
      cyc(10);
      chk("step go", 8'(g + 1), 8'(n_go[e]));
      chk("step pc", 8'h7f, {1'b0, go_pc[e]});
      rchk(8'h00, 8'h40);
      rchk(pa, 8'h00);
      wr(8'h00, 8'h40 | 8'(sh * 3));
      cyc(10);
      chk("once go", 8'(g + 2), 8'(n_go[e]));
      rchk(8'h00, 8'h40);
      rchk(pa, 8'h00);
      wr(8'h01, sh);
      rchk(8'h01, 8'(sh * 2));
      wr(8'h01, 8'h00);
    end
  endtask
  task automatic t_halt;
    int g, a, b;
    dur = 300;
    wr(8'h37, 8'h21);
    wr(8'h01, 8'h28);
    wr(8'h00, 8'h68);
    cyc(10);
    wr(8'h37, 8'h55);
    rchk(8'h37, 8'h00);
    a = n_ab[0];
    b = n_ab[1];
    wr(8'h00, 8'h40);
    g = n_go[0];
    cyc(320);
    chk("hold no abort", 8'(a), 8'(n_ab[0]));
    chk("hold stops", 8'(g), 8'(n_go[0]));
    wr(8'h00, 8'h68);
    cyc(10);
    wr(8'h01, 8'h3c);
    chk("halt abort", 8'(a + 1), 8'(n_ab[0]));
    chk("halt abort b", 8'(b + 1), 8'(n_ab[1]));
    wr(8'h01, 8'h00);
    g = n_go[0];
    cyc(20);
    chk("disabled idle", 8'(g), 8'(n_go[0]));
    wr(8'h00, 8'h40);
    dur = 4;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    cyc(5);
    rst_n = 1'b1;
    cyc(2);
    t_power;
    t_load;
    t_step;
    t_halt;
    tally_and_finish;
  end
  // far beyond the roughly 9k cycles the tests need
  initial begin
    #2000000;
    n_errors++;
    tally_and_finish;
  end
endmodule
